// [design/pfc_consts.svh]
// Purpose: constants for the parallel flash command host controller
// Assumes: 100 MHz sys_clk_i, byte-wide flash with 19 address bits
// Notes on behaviour
// RQ1 - array is 4 KB sectors; a 64 KB block is sixteen adjacent sectors
// RQ2 - smallest part lacks block erase; host still sends the 50h block erase command
// RQ3 - chip erase: AA/555, 55/2AA, 80/555, AA/555, 55/2AA, 10/555
// RQ4 - sector erase: erase prefix, then 30h to an address in the sector
// RQ5 - block erase: erase prefix, then 50h to an address in the block
// RQ6 - byte program: AA/555, 55/2AA, A0/555, then data to target address
// RQ7 - id entry: AA/555, 55/2AA, 90/555
// RQ8 - after id entry, reads return identification codes
// RQ9 - id reads: low address 0 gives maker code, 1 gives part code
// RQ10 - id exit: AA/555, 55/2AA, F0/555
// RQ11 - a single F0h write to any address also leaves id mode
// RQ12 - after id exit the device returns to normal array reads
// RQ13 - byte program finishes within 20 us, typical 16 us
// RQ14 - any erase finishes within 100 ms, typical 55 ms
// RQ15 - host toggles read strobes repeatedly to advance the toggle bit
// RQ16 - host toggles read strobes repeatedly to sample inverted-data status; the host here ends polling on line 6 alone and never checks line 7
// RQ17 - line 7 reads inverted data while programming, 0 while erasing
// RQ18 - line 6 alternates on successive reads while busy
// RQ19 - address latched on later falling edge, data on earlier rising edge
// RQ20 - programming only clears bits; erase alone sets them
// RQ21 - a mismatched sequence write returns the decoder to read mode
// RQ22 - while busy the device ignores commands and returns status
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH
`define PFC_ADDR_W 19
`define PFC_UNLOCK_ADDR1 19'h00555
`define PFC_UNLOCK_ADDR2 19'h002aa
`define PFC_UNLOCK_DATA1 8'haa
`define PFC_UNLOCK_DATA2 8'h55
`define PFC_CMD_ERASE_PRE 8'h80
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_SECTOR_ERASE 8'h30
`define PFC_CMD_BLOCK_ERASE 8'h50
`define PFC_CMD_PROGRAM 8'ha0
`define PFC_CMD_ID_ENTRY 8'h90
`define PFC_CMD_ID_EXIT 8'hf0
`define PFC_ID_MAKER_ADDR 19'h00000
`define PFC_ID_PART_ADDR 19'h00001
`define PFC_SECTOR_BITS 12
`define PFC_BLOCK_BITS 16
`define PFC_CLK_NS 10
`define PFC_BUS_CYCLE_NS 80
`define PFC_BUS_CYCLES ((`PFC_BUS_CYCLE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_PROG_MAX_US 20
`define PFC_ERASE_MAX_MS 100
`define PFC_PROG_CYCLES (`PFC_PROG_MAX_US * 1000 / `PFC_CLK_NS)
`define PFC_ERASE_CYCLES (`PFC_ERASE_MAX_MS * 1000000 / `PFC_CLK_NS)
`endif

// [design/pfc_host.sv]
// Purpose: host controller driving a byte-wide parallel flash through its pins
// Assumes: flash pins sampled synchronously; one request at a time
// Notes: writes command steps, then for program and erase polls the toggle line until it stops
`default_nettype none
`include "pfc_consts.svh"
module pfc_host
  import pfc_pkg::*;
#(
  parameter int unsigned PROG_TIMEOUT = `PFC_PROG_CYCLES,
  parameter int unsigned ERASE_TIMEOUT = `PFC_ERASE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire pfc_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic timeout_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic write_n_o,
  output logic [`PFC_ADDR_W-1:0] addr_o,
  output logic [7:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [7:0] dq_i
);
  typedef struct packed {
    pfc_state_t st;
    pfc_req_t req;
    logic [2:0] step;
    logic [2:0] nsteps;
    logic is_write;
    logic [3:0] cnt;
    logic [31:0] wait_cnt;
    logic have_prev;
    logic prev_tog;
    pfc_pins_t pins;
    logic done;
    logic tmo;
    logic [7:0] rdata;
  } pfc_host_state_t;

  pfc_host_state_t cur;
  pfc_host_state_t next_cur;

  ////////////////////////////////////////////////////////////////////////
  // step table: address and data of each command cycle
  function automatic logic [`PFC_ADDR_W+7:0] step_word(input pfc_req_t r, input logic [2:0] s);
    logic [`PFC_ADDR_W+7:0] w;
    w = {`PFC_UNLOCK_ADDR1, `PFC_UNLOCK_DATA1};
    if (r.op == PFC_OP_ID_EXIT_SHORT) begin
      w = {r.addr, `PFC_CMD_ID_EXIT}; // [RQ11]
    end else if (s == 3'd1 || s == 3'd4) begin
      w = {`PFC_UNLOCK_ADDR2, `PFC_UNLOCK_DATA2};
    end else if (s == 3'd2) begin
      case (r.op)
        PFC_OP_PROGRAM: w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_PROGRAM}; // [RQ6]
        PFC_OP_ID_ENTRY: w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_ID_ENTRY}; // [RQ7]
        PFC_OP_ID_EXIT: w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_ID_EXIT}; // [RQ10]
        default: w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_ERASE_PRE};
      endcase
    end else if (s == 3'd3) begin
      if (r.op == PFC_OP_PROGRAM) begin
        w = {r.addr, r.data}; // [RQ6]
      end else begin
        w = {`PFC_UNLOCK_ADDR1, `PFC_UNLOCK_DATA1};
      end
    end else if (s == 3'd5) begin
      case (r.op)
        PFC_OP_SECTOR_ERASE: w = {r.addr, `PFC_CMD_SECTOR_ERASE}; // [RQ4] [RQ1]
        PFC_OP_BLOCK_ERASE: w = {r.addr, `PFC_CMD_BLOCK_ERASE}; // [RQ5] [RQ2]
        default: w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_CHIP_ERASE}; // [RQ3]
      endcase
    end
    return w;
  endfunction

  // number of bus write cycles each request needs before polling
  function automatic logic [2:0] step_count(input pfc_op_t op);
    case (op)
      PFC_OP_READ: return 3'd0;
      PFC_OP_ID_EXIT_SHORT: return 3'd1;
      PFC_OP_ID_ENTRY, PFC_OP_ID_EXIT: return 3'd3;
      PFC_OP_PROGRAM: return 3'd4;
      default: return 3'd6;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [`PFC_ADDR_W+7:0] w;
    logic busy_op;
    w = step_word(cur.req, cur.step);
    busy_op = cur.req.op == PFC_OP_PROGRAM || cur.req.op == PFC_OP_CHIP_ERASE ||
              cur.req.op == PFC_OP_SECTOR_ERASE || cur.req.op == PFC_OP_BLOCK_ERASE;
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      PFC_ST_IDLE: begin
        // strobes parked high so the flash never sees a stray cycle
        next_cur.pins.chip_sel_n = 1'b1;
        next_cur.pins.out_en_n = 1'b1;
        next_cur.pins.write_n = 1'b1;
        next_cur.pins.dq_oe_n = 1'b1;
        if (req_valid_i) begin
          next_cur.req = req_i;
          next_cur.step = 3'd0;
          next_cur.nsteps = step_count(req_i.op);
          next_cur.is_write = req_i.op != PFC_OP_READ;
          next_cur.tmo = 1'b0;
          next_cur.st = PFC_ST_SETUP;
        end
      end
      PFC_ST_SETUP: begin
        // address and data are driven on the same clock edge as the falling strobes
        next_cur.pins.addr = cur.is_write ? w[`PFC_ADDR_W+7:8] : cur.req.addr; // [RQ9]
        next_cur.pins.dq_out = w[7:0];
        next_cur.pins.dq_oe_n = ~cur.is_write;
        next_cur.pins.chip_sel_n = 1'b0;
        next_cur.pins.write_n = ~cur.is_write; // [RQ19]
        next_cur.pins.out_en_n = cur.is_write;
        next_cur.cnt = 4'(`PFC_BUS_CYCLES);
        next_cur.st = PFC_ST_STROBE;
      end
      PFC_ST_STROBE: begin
        next_cur.cnt = cur.cnt - 4'd1;
        if (cur.cnt == 4'd1) begin
          // raising both strobes together ends the cycle with data still held
          next_cur.pins.write_n = 1'b1; // [RQ19]
          next_cur.pins.out_en_n = 1'b1;
          next_cur.pins.chip_sel_n = 1'b1;
          if (!cur.is_write) begin
            next_cur.rdata = dq_i; // [RQ8] [RQ12]
          end
          next_cur.cnt = 4'(`PFC_BUS_CYCLES);
          next_cur.st = PFC_ST_RECOVER;
        end
      end
      PFC_ST_RECOVER: begin
        next_cur.cnt = cur.cnt - 4'd1;
        if (cur.cnt == 4'd1) begin
          next_cur.pins.dq_oe_n = 1'b1;
          next_cur.step = cur.step + 3'd1;
          if (cur.is_write && cur.step + 3'd1 < cur.nsteps) begin
            next_cur.st = PFC_ST_SETUP;
          end else if (cur.is_write && busy_op) begin
            // no further commands until the device reports completion
            next_cur.have_prev = 1'b0; // [RQ22]
            next_cur.wait_cnt = '0;
            next_cur.st = PFC_ST_POLL_SETUP;
          end else begin
            next_cur.done = 1'b1;
            next_cur.st = PFC_ST_IDLE;
          end
        end
      end
      PFC_ST_POLL_SETUP: begin
        // each poll is a fresh read strobe so the status line advances
        next_cur.pins.chip_sel_n = 1'b0; // [RQ15] [RQ16]
        next_cur.pins.out_en_n = 1'b0;
        next_cur.pins.addr = cur.req.addr;
        next_cur.cnt = 4'(`PFC_BUS_CYCLES);
        next_cur.wait_cnt = cur.wait_cnt + 32'd1;
        next_cur.st = PFC_ST_POLL_HOLD;
      end
      PFC_ST_POLL_HOLD: begin
        next_cur.cnt = cur.cnt - 4'd1;
        next_cur.wait_cnt = cur.wait_cnt + 32'd1;
        if (cur.cnt == 4'd1) begin
          next_cur.pins.chip_sel_n = 1'b1;
          next_cur.pins.out_en_n = 1'b1;
          next_cur.have_prev = 1'b1;
          next_cur.prev_tog = dq_i[6];
          next_cur.rdata = dq_i;
          // two equal reads of the toggle line in a row mean the part is idle
          if (cur.have_prev && cur.prev_tog == dq_i[6]) begin
            next_cur.done = 1'b1; // [RQ18] [RQ17] [RQ20]
            next_cur.st = PFC_ST_IDLE;
          end else if (cur.wait_cnt >= ((cur.req.op == PFC_OP_PROGRAM) ? PROG_TIMEOUT : ERASE_TIMEOUT)) begin
            // give up instead of hanging the requester on a stuck part
            next_cur.tmo = 1'b1; // [RQ13] [RQ14]
            next_cur.done = 1'b1;
            next_cur.st = PFC_ST_IDLE;
          end else begin
            next_cur.st = PFC_ST_POLL_SETUP;
          end
        end
      end
      default: next_cur.st = PFC_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // strobes reset high so a reset mid-cycle cannot leave a write pending
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.st <= PFC_ST_IDLE;
      cur.pins.chip_sel_n <= 1'b1;
      cur.pins.out_en_n <= 1'b1;
      cur.pins.write_n <= 1'b1;
      cur.pins.dq_oe_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ready is combinational; every pin comes straight from a flop
  assign req_ready_o = cur.st == PFC_ST_IDLE;
  assign done_o = cur.done;
  assign rdata_o = cur.rdata;
  assign timeout_o = cur.tmo;
  assign chip_sel_n_o = cur.pins.chip_sel_n;
  assign out_en_n_o = cur.pins.out_en_n;
  assign write_n_o = cur.pins.write_n;
  assign addr_o = cur.pins.addr;
  assign dq_o = cur.pins.dq_out;
  assign dq_oe_n_o = cur.pins.dq_oe_n;
endmodule
`default_nettype wire

// [design/pfc_pkg.sv]
// Purpose: types for the parallel flash command host controller
// Assumes: constants come from pfc_consts.svh
// Notes: command codes and the pin bundle
`default_nettype none
`include "pfc_consts.svh"
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ, PFC_OP_PROGRAM, PFC_OP_CHIP_ERASE, PFC_OP_SECTOR_ERASE,
    PFC_OP_BLOCK_ERASE, PFC_OP_ID_ENTRY, PFC_OP_ID_EXIT, PFC_OP_ID_EXIT_SHORT
  } pfc_op_t;
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic write_n;
    logic [`PFC_ADDR_W-1:0] addr;
    logic [7:0] dq_out;
    logic dq_oe_n;
  } pfc_pins_t;
  typedef struct packed {
    pfc_op_t op;
    logic [`PFC_ADDR_W-1:0] addr;
    logic [7:0] data;
  } pfc_req_t;
  typedef enum logic [2:0] {
    PFC_ST_IDLE, PFC_ST_SETUP, PFC_ST_STROBE, PFC_ST_RECOVER, PFC_ST_POLL_SETUP, PFC_ST_POLL_HOLD
  } pfc_state_t;
endpackage
`default_nettype wire

// [dv/pfc_flash_model.sv]
// Purpose: flash device model facing the host controller
// Assumes: pins sampled on the host clock
// Notes: busy spans shortened by parameters
`default_nettype none
module pfc_flash_model #(
  parameter int PROG_BUSY = 60,
  parameter int ERASE_BUSY = 400,
  parameter logic [7:0] MAKER = 8'h00,
  parameter logic [7:0] PART = 8'h00
) (
  input wire logic clk_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] din_i,
  output logic [7:0] dout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [1 << 19];
  logic [18:0] la;
  logic [7:0] pd, last;
  logic wr, rd, pw = 1'b0, prd = 1'b0, tog = 1'b0, idm = 1'b0, prog = 1'b0;
  int st = 0, busy = 0, sh;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    dout_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    wr = !cs_n_i && !we_n_i;
    rd = !cs_n_i && !oe_n_i;
    if (busy > 0) busy--;
    if (wr && !pw) la = addr_i;
    if (!wr && pw && busy == 0) begin
      if (pd == 8'hf0 && st != 6) begin
        idm = 1'b0;
        st = 0;
      end else case (st)
        0, 3: st = (la == 19'h555 && pd == 8'haa) ? st + 1 : 0;
        1, 4: st = (la == 19'h2aa && pd == 8'h55) ? st + 1 : 0;
        2: begin
          st = (la != 19'h555) ? 0 : (pd == 8'h80) ? 3 : (pd == 8'ha0) ? 6 : 0;
          idm = idm || (la == 19'h555 && pd == 8'h90);
        end
        5: begin
          if (pd inside {8'h10, 8'h30, 8'h50}) begin
            sh = (pd == 8'h10) ? 19 : (pd == 8'h30) ? 12 : 16;
            foreach (mem[i]) if ((i >> sh) == (int'(la) >> sh)) mem[i] = 8'hff;
            busy = ERASE_BUSY;
            prog = 1'b0;
          end
          st = 0;
        end
        default: begin
          mem[la] = mem[la] & pd;
          last = pd;
          prog = 1'b1;
          busy = PROG_BUSY;
          st = 0;
        end
      endcase
    end
    if (rd && !prd) begin
      if (busy > 0) begin
        dout_o <= {prog ? ~last[7] : 1'b0, tog, 6'h00};
        tog = !tog;
      end else dout_o <= idm ? (addr_i[0] ? PART : MAKER) : mem[addr_i];
    end else if (!rd) dout_o <= ~dout_o; // released bus must not hold a stale byte
    pw = wr;
    prd = rd;
    pd = din_i;
  end
endmodule
`default_nettype wire

// [dv/pfc_host_chk.sv]
// Purpose: pin-level checks on the flash host controller
// Assumes: one clock, synchronous active-high reset
// Notes: strobe widths follow the eight-cycle bus step
`default_nettype none
`include "pfc_consts.svh"
module pfc_host_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic [7:0] rdata_o,
  input wire logic chip_sel_n_o,
  input wire logic out_en_n_o,
  input wire logic write_n_o,
  input wire logic [`PFC_ADDR_W-1:0] addr_o,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_n_o,
  input wire logic [7:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_we_width: assert property ($fell(write_n_o) |-> !write_n_o [*8] ##1 write_n_o)
    else $error("write strobe width wrong");
  chk_oe_width: assert property ($fell(out_en_n_o) |-> !out_en_n_o [*8] ##1 out_en_n_o)
    else $error("read strobe width wrong");
  chk_write_inhibit: assert property (!write_n_o |-> out_en_n_o && !chip_sel_n_o && !dq_oe_n_o)
    else $error("write cycle not qualified");
  chk_write_hold: assert property (!write_n_o && !$past(write_n_o) |-> $stable(addr_o) && $stable(dq_o))
    else $error("address or data moved in write");
  chk_data_after_we: assert property ($rose(write_n_o) |-> !dq_oe_n_o && $stable(dq_o))
    else $error("data dropped at write rise");
  chk_take_busy: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready stayed high after take");
  chk_read_capture: assert property ($rose(out_en_n_o) |-> rdata_o == $past(dq_i))
    else $error("read byte not captured");
  chk_done_idle: assert property (done_o |-> chip_sel_n_o && write_n_o && out_en_n_o ##1 !done_o)
    else $error("done while bus busy or too long");
  chk_read_release: assert property (!out_en_n_o |-> !chip_sel_n_o && write_n_o && dq_oe_n_o)
    else $error("read cycle not qualified");
endmodule
`default_nettype wire

// [dv/test_parallel_flash_command_interface.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model answers on the host clock
// Notes: busy spans and timeouts shortened
`default_nettype none
module test_parallel_flash_command_interface;
  import pfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary id value
  localparam logic [7:0] PART = 8'h3c; // arbitrary id value
  logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, done, timeout, cs_n, oe_n, we_n, dq_oe_n;
  logic [18:0] addr, a;
  logic [7:0] dq_out, dq_in, rdata, d;
  pfc_req_t req = '0;
  int mismatches = 0, check_count = 0, seed = 78917;
  logic [7:0] ref_mem [int];
  logic [18:0] offs [3] = '{19'h00000, 19'h01000, 19'h10000};
  pfc_op_t eops [3] = '{PFC_OP_SECTOR_ERASE, PFC_OP_BLOCK_ERASE, PFC_OP_CHIP_ERASE};
  int shs [3] = '{12, 16, 19};
  always #5 sys_clk = ~sys_clk;
  pfc_host #(.PROG_TIMEOUT(200), .ERASE_TIMEOUT(2000)) dut (.sys_clk_i(sys_clk), .rst_i(rst),
    .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata),
    .timeout_o(timeout), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .write_n_o(we_n), .addr_o(addr),
    .dq_o(dq_out), .dq_oe_n_o(dq_oe_n), .dq_i(dq_in));
  pfc_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.clk_i(sys_clk), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .addr_i(addr), .din_i(dq_out), .dout_o(dq_in));
  ////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] ref_rd(int x);
    return ref_mem.exists(x) ? ref_mem[x] : 8'hff;
  endfunction
  task automatic op(pfc_op_t o, logic [18:0] oa, logic [7:0] od);
    int n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{o, oa, od};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("done", {7'h0, done}, 8'h01);
    chk("timeout", {7'h0, timeout}, 8'h00);
  endtask
  task automatic rd_chk(logic [18:0] ra, logic [7:0] exp);
    op(PFC_OP_READ, ra, 8'h00);
    chk("rdata", rdata, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    // a few times the expected run, well under the cycle budget
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    op(PFC_OP_ID_ENTRY, 19'h0, 8'h00);
    rd_chk(19'h00000, MAKER);
    rd_chk(19'h70001, PART);
    op(PFC_OP_ID_EXIT_SHORT, 19'h12345, 8'hf0);
    rd_chk(19'h00000, 8'hff);
    op(PFC_OP_ID_ENTRY, 19'h0, 8'h00);
    op(PFC_OP_ID_EXIT, 19'h0, 8'h00);
    rd_chk(19'h00001, 8'hff);
    for (int i = 0; i < 6; i++) begin
      if (i % 2 == 0) a = 19'($random(seed));
      d = 8'($random(seed));
      op(PFC_OP_PROGRAM, a, d);
      ref_mem[a] = ref_rd(a) & d;
      rd_chk(a, ref_rd(a));
    end
    for (int j = 0; j < 3; j++) begin
      a = 19'($random(seed));
      for (int k = 0; k < 3; k++) begin
        op(PFC_OP_PROGRAM, a ^ offs[k], 8'h00);
        ref_mem[a ^ offs[k]] = 8'h00;
      end
      op(eops[j], a, 8'h00);
      foreach (ref_mem[x]) if ((x >> shs[j]) == (int'(a) >> shs[j])) ref_mem[x] = 8'hff;
      for (int k = 0; k < 3; k++) rd_chk(a ^ offs[k], ref_rd(a ^ offs[k]));
    end
    end_sim();
  end
endmodule
bind pfc_host pfc_host_chk chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o), .chip_sel_n_o(chip_sel_n_o),
  .out_en_n_o(out_en_n_o), .write_n_o(write_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
  .dq_i(dq_i));
`default_nettype wire
